/* File: core/lsd_leader_select.sv */
// Purpose: leader selection and dynamic priority for one timing instance
// Assumes: received announce datasets arrive as one-cycle strobes
// Notes: best foreign dataset held until cleared; no aging of candidates
`timescale 1ns/1ps
module lsd_leader_select #(
	parameter int unsigned TMR_W = 40
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [1:0] i_mode,
	input wire logic [7:0] i_prio1_base,
	input wire logic i_prio2_load,
	input wire logic [7:0] i_prio2_val,
	input wire logic [47:0] i_mac,
	input wire logic i_ref_locked,
	input wire logic i_dyn_en,
	input wire logic i_dyn_sel_p2,
	input wire logic [7:0] i_dyn_offset,
	input wire logic i_dyn_reset,
	input wire logic [31:0] i_ann_period_cyc,
	input wire logic [7:0] i_ann_timeout_cnt,
	input wire logic i_ann_valid,
	input wire logic [lsd_pkg::DS_W-1:0] i_ann_ds,
	input wire logic i_foreign_clear,
	output logic o_active,
	output logic o_eligible,
	output logic o_offset_applied,
	output logic [7:0] o_adv_prio1,
	output logic [7:0] o_adv_prio2,
	output logic [7:0] o_adv_class,
	output logic [7:0] o_adv_accuracy,
	output logic [15:0] o_adv_variance,
	output logic [lsd_pkg::ID_W-1:0] o_adv_identity,
	output logic [15:0] o_udp_event_port,
	output logic [15:0] o_udp_general_port,
	output logic [3:0] o_ip_version
);
	logic [7:0] prio2_base_r;
	logic [lsd_pkg::DS_W-1:0] best_r;
	logic best_valid_r;
	logic active_r;
	logic applied_r;
	logic cleared_r;
	logic [lsd_pkg::ID_W-1:0] own_id;
	logic [lsd_pkg::DS_W-1:0] own_ds;
	logic [lsd_pkg::DS_W-1:0] own_base_ds;
	logic ann_better;
	logic own_better;
	logic eligible;
	logic active_nxt;
	logic tmr_done;
	logic [7:0] dyn_prio;
	logic [7:0] class_v;
	logic [7:0] acc_v;

	// eui-64 from mac
	assign own_id = {i_mac[47:24], lsd_pkg::MAC_ID_FILL, i_mac[23:0]};
	assign class_v = i_ref_locked ? lsd_pkg::CLASS_LOCKED : lsd_pkg::CLASS_HOLDOVER;
	assign acc_v = i_ref_locked ? lsd_pkg::ACC_LOCKED : lsd_pkg::ACC_HOLDOVER;

	// saturating subtract of the selected priority
	always_comb begin
		logic [7:0] base;
		base = i_dyn_sel_p2 ? prio2_base_r : i_prio1_base;
		dyn_prio = (base > i_dyn_offset) ? base - i_dyn_offset : 8'h00;
	end

	always_comb begin
		o_adv_prio1 = i_prio1_base;
		o_adv_prio2 = prio2_base_r;
		if (applied_r && active_r) begin
			if (i_dyn_sel_p2) begin
				o_adv_prio2 = dyn_prio;
			end else begin
				o_adv_prio1 = dyn_prio;
			end
		end
	end

	assign own_ds = {o_adv_prio1, class_v, acc_v, lsd_pkg::VARIANCE_CONST, o_adv_prio2, own_id};
	// reference dataset with no offset, only watched by the checks below
	assign own_base_ds = {i_prio1_base, class_v, acc_v, lsd_pkg::VARIANCE_CONST, prio2_base_r, own_id};
	// follower-only and out-of-range prio1 lock the instance out of leading
	assign eligible = (i_prio1_base <= lsd_pkg::PRIO1_ELIG_MAX) &&
		(lsd_pkg::lsd_mode_type'(i_mode) != lsd_pkg::LSD_MODE_FOLLOWER);

	lsd_compare u_cmp_ann (
		.i_a(i_ann_ds),
		.i_b(best_r),
		.o_a_better(ann_better)
	);
	lsd_compare u_cmp_own (
		.i_a(own_ds),
		.i_b(best_r),
		.o_a_better(own_better)
	);

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			prio2_base_r <= lsd_pkg::PRIO2_RESET;
		end else if (i_prio2_load) begin
			prio2_base_r <= i_prio2_val;
		end
	end

	// best foreign dataset, decided locally from announces only
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			best_r <= '1;
			best_valid_r <= 1'b0;
		end else if (i_ann_valid && (ann_better || !best_valid_r)) begin
			best_r <= i_ann_ds;
			best_valid_r <= 1'b1;
		end else if (i_foreign_clear) begin
			best_r <= '1;
			best_valid_r <= 1'b0;
		end
	end

	// own dataset vs best foreign; with none present an eligible instance leads
	assign active_nxt = eligible && (!best_valid_r || own_better);

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			active_r <= 1'b0;
		end else begin
			active_r <= active_nxt;
		end
	end

	lsd_dyn_timer #(
		.CNT_W(TMR_W)
	) u_tmr (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_run(active_r && i_dyn_en && !applied_r && !cleared_r),
		.i_period_cyc(i_ann_period_cyc),
		.i_timeout_cnt(i_ann_timeout_cnt),
		.o_done(tmr_done)
	);

	// manual reset holds offset off until the lead is lost or i_dyn_en drops
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			applied_r <= 1'b0;
			cleared_r <= 1'b0;
		end else if (!active_r || !i_dyn_en) begin
			applied_r <= 1'b0;
			cleared_r <= 1'b0;
		end else if (i_dyn_reset) begin
			applied_r <= 1'b0;
			cleared_r <= 1'b1;
		end else if (tmr_done) begin
			applied_r <= 1'b1;
		end
	end

	assign o_active = active_r;
	assign o_eligible = eligible;
	assign o_offset_applied = applied_r;
	assign o_adv_class = class_v;
	assign o_adv_accuracy = acc_v;
	assign o_adv_variance = lsd_pkg::VARIANCE_CONST;
	assign o_adv_identity = own_id;
	assign o_udp_event_port = lsd_pkg::UDP_EVENT_PORT;
	assign o_udp_general_port = lsd_pkg::UDP_GENERAL_PORT;
	assign o_ip_version = lsd_pkg::IP_VERSION;

	property p_follower_never_leads;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(lsd_pkg::lsd_mode_type'(i_mode) == lsd_pkg::LSD_MODE_FOLLOWER) |=> !active_r;
	endproperty
	a_follower_never_leads: assert property (p_follower_never_leads) else $error("follower led");

	property p_prio1_elig;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(i_prio1_base > lsd_pkg::PRIO1_ELIG_MAX) |=> !active_r;
	endproperty
	a_prio1_elig: assert property (p_prio1_elig) else $error("ineligible prio1 led");

	property p_passive_base;
		@(posedge i_mclk) disable iff (!i_rst_b)
		!active_r |-> (o_adv_prio1 == i_prio1_base && o_adv_prio2 == prio2_base_r);
	endproperty
	a_passive_base: assert property (p_passive_base) else $error("passive offset seen");

	sequence s_lose_lead;
		active_r && !active_nxt;
	endsequence

	sequence s_base_adv;
		o_adv_prio1 == i_prio1_base && o_adv_prio2 == prio2_base_r;
	endsequence

	// advertised value drops back with active_r; the applied flag follows one edge later
	property p_loss_restores;
		@(posedge i_mclk) disable iff (!i_rst_b)
		s_lose_lead |=> s_base_adv ##1 !applied_r;
	endproperty
	a_loss_restores: assert property (p_loss_restores) else $error("offset kept after loss");

	property p_manual_reset;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(active_r && active_nxt && i_dyn_en && i_dyn_reset) |=> (!applied_r && cleared_r);
	endproperty
	a_manual_reset: assert property (p_manual_reset) else $error("manual reset ignored");

	property p_class_acc;
		@(posedge i_mclk) disable iff (!i_rst_b)
		i_ref_locked |-> (o_adv_class == lsd_pkg::CLASS_LOCKED && o_adv_accuracy == lsd_pkg::ACC_LOCKED);
	endproperty
	a_class_acc: assert property (p_class_acc) else $error("locked quality wrong");

	property p_hold_quality;
		@(posedge i_mclk) disable iff (!i_rst_b)
		!i_ref_locked |-> (o_adv_class == lsd_pkg::CLASS_HOLDOVER && o_adv_accuracy == lsd_pkg::ACC_HOLDOVER);
	endproperty
	a_hold_quality: assert property (p_hold_quality) else $error("holdover quality wrong");

	property p_sat;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(applied_r && active_r && i_dyn_sel_p2 && prio2_base_r <= i_dyn_offset) |-> o_adv_prio2 == 8'h00;
	endproperty
	a_sat: assert property (p_sat) else $error("offset wrapped");

	property p_no_early_apply;
		@(posedge i_mclk) disable iff (!i_rst_b)
		($rose(active_r) && i_ann_period_cyc != 32'h0 && i_ann_timeout_cnt != 8'h00) |=> !applied_r;
	endproperty
	a_no_early_apply: assert property (p_no_early_apply) else $error("offset applied without delay");

	property p_dyn_off;
		@(posedge i_mclk) disable iff (!i_rst_b)
		!i_dyn_en |=> !applied_r;
	endproperty
	a_dyn_off: assert property (p_dyn_off) else $error("offset applied while disabled");

	property p_passive_no_apply;
		@(posedge i_mclk) disable iff (!i_rst_b)
		!active_r |=> !applied_r;
	endproperty
	a_passive_no_apply: assert property (p_passive_no_apply) else $error("offset armed while passive");

	property p_own_base;
		@(posedge i_mclk) disable iff (!i_rst_b)
		!active_r |-> own_ds == own_base_ds;
	endproperty
	a_own_base: assert property (p_own_base) else $error("passive dataset not base");

	property p_cleared_holds;
		@(posedge i_mclk) disable iff (!i_rst_b)
		cleared_r |-> !applied_r;
	endproperty
	a_cleared_holds: assert property (p_cleared_holds) else $error("offset back after manual reset");

	property p_offset_p2;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(applied_r && active_r && i_dyn_sel_p2 && prio2_base_r > i_dyn_offset) |->
			(o_adv_prio2 == prio2_base_r - i_dyn_offset && o_adv_prio1 == i_prio1_base);
	endproperty
	a_offset_p2: assert property (p_offset_p2) else $error("prio2 offset wrong");

	property p_sat_p1;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(applied_r && active_r && !i_dyn_sel_p2 && i_prio1_base <= i_dyn_offset) |->
			(o_adv_prio1 == 8'h00 && o_adv_prio2 == prio2_base_r);
	endproperty
	a_sat_p1: assert property (p_sat_p1) else $error("prio1 offset wrapped");

	property p_prio2_load;
		@(posedge i_mclk) disable iff (!i_rst_b)
		i_prio2_load |=> prio2_base_r == $past(i_prio2_val);
	endproperty
	a_prio2_load: assert property (p_prio2_load) else $error("prio2 not loaded");

	property p_first_ann;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(i_ann_valid && !best_valid_r) |=> (best_valid_r && best_r == $past(i_ann_ds));
	endproperty
	a_first_ann: assert property (p_first_ann) else $error("first announce not kept");

	// no foreign candidate known: an eligible instance takes the lead on its own
	property p_elig_lead;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(eligible && !best_valid_r) |=> active_r;
	endproperty
	a_elig_lead: assert property (p_elig_lead) else $error("eligible instance did not lead");
endmodule

/* File: core/lsd_pkg.sv */
// Purpose: shared constants for leader selection and dynamic priority
// Assumes: single 100 MHz clock domain
// Notes: clock quality codes and transport ports are fixed values
package lsd_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam logic [7:0] PRIO_MAX = 8'hff;
	localparam logic [7:0] PRIO1_ELIG_MAX = 8'h80;
	localparam logic [7:0] PRIO2_RESET = 8'h80;
	localparam logic [7:0] CLASS_LOCKED = 8'h06;
	localparam logic [7:0] CLASS_HOLDOVER = 8'h07;
	localparam logic [7:0] ACC_LOCKED = 8'h21;
	localparam logic [7:0] ACC_HOLDOVER = 8'h26;
	localparam logic [15:0] VARIANCE_CONST = 16'h3a00;
	localparam logic [15:0] UDP_EVENT_PORT = 16'h013f;
	localparam logic [15:0] UDP_GENERAL_PORT = 16'h0140;
	localparam logic [3:0] IP_VERSION = 4'h4;
	localparam logic [15:0] MAC_ID_FILL = 16'hfffe;
	localparam int unsigned DS_W = 112;
	localparam int unsigned ID_W = 64;
	localparam int unsigned DLY_MULT = 2;
	localparam logic [7:0] DLY_MULT_8 = 8'h02;
	typedef enum logic [1:0] {
		LSD_MODE_OC = 2'b00,
		LSD_MODE_LEADER = 2'b01,
		LSD_MODE_FOLLOWER = 2'b10
	} lsd_mode_type;
	typedef enum logic [1:0] {
		LSD_DP_IDLE = 2'b00,
		LSD_DP_WAIT = 2'b01,
		LSD_DP_APPLIED = 2'b10,
		LSD_DP_CLEARED = 2'b11
	} lsd_dp_state_type;
endpackage

/* File: core/lsd_compare.sv */
// Purpose: ordered dataset comparison of two candidate leaders
// Assumes: datasets packed prio1,class,acc,var,prio2,identity msb first
// Notes: purely combinational; smaller value wins at every step
`timescale 1ns/1ps
module lsd_compare (
	input wire logic [lsd_pkg::DS_W-1:0] i_a,
	input wire logic [lsd_pkg::DS_W-1:0] i_b,
	output logic o_a_better
);
	// packed msb-first order makes one unsigned compare equal to the field-by-field walk
	assign o_a_better = i_a < i_b;
endmodule

/* File: core/lsd_dyn_timer.sv */
// Purpose: settling delay counter before dynamic offset is applied
// Assumes: announce period given in clock cycles
// Notes: target recomputed from live inputs; restart clears the count
`timescale 1ns/1ps
module lsd_dyn_timer #(
	parameter int unsigned CNT_W = 40
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_run,
	input wire logic [31:0] i_period_cyc,
	input wire logic [7:0] i_timeout_cnt,
	output logic o_done
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] target;
	// widen before multiplying so the product is not cut at 32 bits
	assign target = CNT_W'(i_period_cyc) * CNT_W'(i_timeout_cnt) * CNT_W'(lsd_pkg::DLY_MULT_8);
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_r <= '0;
		end else if (!i_run) begin
			cnt_r <= '0;
		end else if (cnt_r < target) begin
			cnt_r <= cnt_r + CNT_W'(1);
		end
	end
	assign o_done = i_run && (cnt_r >= target);
endmodule

/* File: tb/lsd_peer_model.sv */
// Purpose: far-side timing instance sending announce datasets
// Assumes: one announce strobe per call, driven at the falling edge
// Notes: dataset bus carries no stale copy once the strobe drops
`timescale 1ns/1ps
module lsd_peer_model (
	input wire logic i_mclk,
	output logic o_ann_valid,
	output logic [lsd_pkg::DS_W-1:0] o_ann_ds
);
	initial begin
		o_ann_valid = 1'b0;
		o_ann_ds = '0;
	end
	// peer decides from its own dataset only, no negotiation
	task automatic announce(input logic [lsd_pkg::DS_W-1:0] ds);
		@(negedge i_mclk);
		o_ann_valid = 1'b1;
		o_ann_ds = ds;
		@(negedge i_mclk);
		o_ann_valid = 1'b0;
		o_ann_ds = ~ds;
	endtask
endmodule

/* File: tb/testbench.sv */
// Purpose: self-checking bench for leader selection and dynamic priority
// Assumes: announce period 4 clocks, timeout 3, so offset waits 24 clocks
// Notes: inputs change at the falling edge only
`timescale 1ns/1ps
module testbench;
	localparam logic [47:0] MAC = 48'h001122334455;
	localparam logic [63:0] OWN_ID = {MAC[47:24], 16'hfffe, MAC[23:0]};
	logic i_mclk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [1:0] i_mode = 2'b00;
	logic [7:0] i_prio1_base = 8'h0a;
	logic i_prio2_load = 1'b0;
	logic [7:0] i_prio2_val = 8'h00;
	logic [47:0] i_mac = MAC;
	logic i_ref_locked = 1'b1;
	logic i_dyn_en = 1'b0;
	logic i_dyn_sel_p2 = 1'b1;
	logic [7:0] i_dyn_offset = 8'h02;
	logic i_dyn_reset = 1'b0;
	logic [31:0] i_ann_period_cyc = 32'h00000004;
	logic [7:0] i_ann_timeout_cnt = 8'h03;
	logic i_foreign_clear = 1'b0;
	logic i_ann_valid;
	logic [lsd_pkg::DS_W-1:0] i_ann_ds;
	logic o_active, o_eligible, o_offset_applied;
	logic [7:0] o_adv_prio1, o_adv_prio2, o_adv_class, o_adv_accuracy;
	logic [15:0] o_adv_variance, o_udp_event_port, o_udp_general_port;
	logic [63:0] o_adv_identity;
	logic [3:0] o_ip_version;
	int fails = 0;
	int n_checks = 0;
	logic [111:0] tbl [11];
	logic exp_act [11] = '{0, 1, 0, 1, 0, 1, 0, 0, 1, 0, 1};
	logic [111:0] beat = {8'h00, 8'h05, 8'h21, 16'h3a00, 8'h80, OWN_ID};

	lsd_leader_select u_dut (.i_mclk, .i_rst_b, .i_mode, .i_prio1_base, .i_prio2_load, .i_prio2_val, .i_mac,
		.i_ref_locked, .i_dyn_en, .i_dyn_sel_p2, .i_dyn_offset, .i_dyn_reset, .i_ann_period_cyc,
		.i_ann_timeout_cnt, .i_ann_valid, .i_ann_ds, .i_foreign_clear, .o_active, .o_eligible,
		.o_offset_applied, .o_adv_prio1, .o_adv_prio2, .o_adv_class, .o_adv_accuracy, .o_adv_variance,
		.o_adv_identity, .o_udp_event_port, .o_udp_general_port, .o_ip_version);
	lsd_peer_model u_peer (.i_mclk(i_mclk), .o_ann_valid(i_ann_valid), .o_ann_ds(i_ann_ds));

	always #5 i_mclk = ~i_mclk;

	function automatic logic [111:0] mk(input logic [7:0] p1, c, a, input logic [15:0] v,
		input logic [7:0] p2, input logic [63:0] id);
		return {p1, c, a, v, p2, id};
	endfunction
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge i_mclk);
	endtask
	task automatic pulse(ref logic s);
		@(negedge i_mclk);
		s = 1'b1;
		@(negedge i_mclk);
		s = 1'b0;
	endtask
	task automatic wait_act(input logic v);
		for (int k = 0; k < 50 && o_active !== v; k++) @(negedge i_mclk);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#100us;
		fails++;
		report_and_stop;
	end

	initial begin
		tbl = '{mk(8'h09, 8'h06, 8'h21, 16'h3a00, 8'h80, OWN_ID), mk(8'h0b, 8'h00, 8'h00, 16'h0000, 8'h00, 0),
			mk(8'h0a, 8'h05, 8'h21, 16'h3a00, 8'h80, OWN_ID), mk(8'h0a, 8'h07, 8'h21, 16'h3a00, 8'h00, 0),
			mk(8'h0a, 8'h06, 8'h20, 16'h3a00, 8'h80, OWN_ID), mk(8'h0a, 8'h06, 8'h22, 16'h0000, 8'h00, 0),
			mk(8'h0a, 8'h06, 8'h21, 16'h39ff, 8'hff, OWN_ID), mk(8'h0a, 8'h06, 8'h21, 16'h3a00, 8'h7f, OWN_ID),
			mk(8'h0a, 8'h06, 8'h21, 16'h3a00, 8'h81, 0), mk(8'h0a, 8'h06, 8'h21, 16'h3a00, 8'h80, OWN_ID - 1),
			mk(8'h0a, 8'h06, 8'h21, 16'h3a00, 8'h80, OWN_ID + 1)};
		cyc(2);
		i_rst_b = 1'b1;
		cyc(3);
		chk("class", o_adv_class, 8'h06);
		chk("accuracy", o_adv_accuracy, 8'h21);
		chk("variance", o_adv_variance, 16'h3a00);
		chk("event port", o_udp_event_port, 16'h013f);
		chk("general port", o_udp_general_port, 16'h0140);
		chk("ip version", o_ip_version, 4'h4);
		chk("identity", o_adv_identity, OWN_ID);
		chk("prio2", o_adv_prio2, 8'h80);
		chk("active", o_active, 1'b1);
		i_ref_locked = 1'b0;
		cyc(1);
		chk("class", o_adv_class, 8'h07);
		chk("accuracy", o_adv_accuracy, 8'h26);
		i_ref_locked = 1'b1;
		$display("test basics done");
		for (int i = 0; i < 11; i++) begin
			pulse(i_foreign_clear);
			u_peer.announce(tbl[i]);
			cyc(3);
			chk("active", o_active, exp_act[i]);
		end
		$display("test compare done");
		pulse(i_foreign_clear);
		i_prio1_base = 8'h81;
		cyc(3);
		chk("eligible", o_eligible, 1'b0);
		chk("active", o_active, 1'b0);
		i_prio1_base = 8'h80;
		cyc(3);
		chk("eligible", o_eligible, 1'b1);
		chk("active", o_active, 1'b1);
		i_mode = 2'b10;
		cyc(3);
		chk("active", o_active, 1'b0);
		i_mode = 2'b00;
		i_prio1_base = 8'h0a;
		$display("test eligibility done");
		i_prio2_val = 8'h64;
		pulse(i_prio2_load);
		u_peer.announce(beat);
		wait_act(1'b0);
		chk("active", o_active, 1'b0);
		i_dyn_en = 1'b1;
		pulse(i_foreign_clear);
		wait_act(1'b1);
		chk("active", o_active, 1'b1);
		cyc(15);
		chk("applied", o_offset_applied, 1'b0);
		chk("prio2", o_adv_prio2, 8'h64);
		cyc(20);
		chk("applied", o_offset_applied, 1'b1);
		chk("prio2", o_adv_prio2, 8'h62);
		chk("prio1", o_adv_prio1, 8'h0a);
		pulse(i_dyn_reset);
		cyc(2);
		chk("applied", o_offset_applied, 1'b0);
		chk("prio2", o_adv_prio2, 8'h64);
		// toggling the enable re-arms the offset after a manual reset
		i_dyn_sel_p2 = 1'b0;
		i_dyn_offset = 8'h20;
		i_dyn_en = 1'b0;
		cyc(2);
		i_dyn_en = 1'b1;
		cyc(35);
		chk("prio1", o_adv_prio1, 8'h00);
		u_peer.announce(beat);
		wait_act(1'b0);
		chk("active", o_active, 1'b0);
		chk("prio1", o_adv_prio1, 8'h0a);
		$display("test dynamic priority done");
		report_and_stop;
	end
endmodule
